/* bench/ssp_chk.sv */
/*
  Port assertions for the slave serial port top.
  Assumes one clk domain and rst asynchronous, active high.
*/
`timescale 1ns/10ps
module ssp_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        shift_clock_pin,
  input wire logic        data_pin_in,
  input wire logic        data_pin_out,
  input wire logic        data_pin_oe,
  input wire logic        core_low_power,
  input wire logic        wake_req,
  input wire logic        irq_vector
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Bus answer: one cycle after a taken request, one cycle long
  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  // Registers are bytes; unmapped places read zero
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 5'h18 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Wake only from a low-power core; a vectored interrupt also wakes
  a_wake_in_sleep: assert property (wake_req |-> core_low_power)
    else $error("wake while awake");
  a_irq_wakes: assert property (irq_vector && $stable(irq_vector) && core_low_power
                                && $stable(core_low_power) |-> wake_req)
    else $error("interrupt did not wake");
  a_quiet_after_rst: assert property ($fell(rst) |-> !data_pin_oe && !wb_ack_o && !irq_vector)
    else $error("outputs active after reset");
endmodule // ssp_chk

bind ssp_top ssp_chk ssp_chk_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .shift_clock_pin(shift_clock_pin),
  .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
  .core_low_power(core_low_power), .wake_req(wake_req), .irq_vector(irq_vector));

/* bench/ssp_master_model.sv */
/*
  External synchronous master: makes the shift clock only within frames.
  Assumes a 160 ns shift clock, idle high, falling edge samples.
*/
`timescale 1ns/10ps
module ssp_master_model (
  input  wire logic data_pin_out,
  input  wire logic data_pin_oe,
  output logic      shift_clock_pin,
  output logic      data_pin_in
);
  initial begin
    shift_clock_pin = 1'b1;
    data_pin_in = 1'b0;
  end
  // One frame of n bits, least significant first
  task automatic xfer(input logic [8:0] tx, input int n, output logic [8:0] rx);
    rx = 9'h000;
    #3;
    for (int i = 0; i < n; i++) begin
      data_pin_in = tx[i];
      #80 rx[i] = data_pin_oe ? data_pin_out : ~data_pin_out; // Released pin reads inverted
      shift_clock_pin = 1'b0;
      #80 shift_clock_pin = 1'b1;
    end
    data_pin_in = ~tx[n-1];         // Released line shows no stale bit
  endtask
endmodule // ssp_master_model

/* bench/tb.sv */
/*
  Self-checking bench for the slave serial port top.
  Assumes the master model in its own file and a 125 MHz clk.
*/
`timescale 1ns/10ps
module tb;
  logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic        data_pin_out, data_pin_oe, core_low_power, wake_req, irq_vector;
  wire logic   shift_clock_pin, data_pin_in;
  logic [8:0]  rx, w;
  logic [7:0]  a, b;
  int          fails, total_checks;
  localparam logic [4:0] RA [4] = '{ssp_pkg::OFF_TX_STAT, ssp_pkg::OFF_RX_STAT,
                                    ssp_pkg::OFF_BAUD, ssp_pkg::OFF_INT_CTRL};
  localparam logic [7:0] RV [4] = '{ssp_pkg::TX_STAT_RST, ssp_pkg::RX_STAT_RST,
                                    ssp_pkg::BAUD_RST, ssp_pkg::INT_CTRL_RST};
  localparam logic [4:0] FLG = ssp_pkg::OFF_INT_FLAG;

  ssp_top ssp_top_i (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .shift_clock_pin(shift_clock_pin),
    .data_pin_in(data_pin_in), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .core_low_power(core_low_power), .wake_req(wake_req), .irq_vector(irq_vector));
  ssp_master_model ssp_master_model_i (.data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .shift_clock_pin(shift_clock_pin), .data_pin_in(data_pin_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic cycle held until ack is sampled, then one idle cycle
  task automatic wb(input logic we, input logic [4:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= ad;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    if (n >= 50) begin
      fails++;
      print_verdict();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] ad, input logic [7:0] d);
    wb(1'b1, ad, d);
  endtask

  task automatic rchk(input string nm, input logic [4:0] ad, input logic [31:0] e);
    wb(1'b0, ad, 8'h00);
    chk(nm, q, e);
  endtask

  // One frame from the master, then time for the pin synchronisers
  task automatic sh(input logic [8:0] t, input int n);
    ssp_master_model_i.xfer(t, n, rx);
    repeat (8) @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, core_low_power} = 4'h0;
    wb_adr_i = 5'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'h59f8));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rchk("reset value", RA[i], {24'h0, RV[i]});
    rchk("unmapped read", 5'h1c, 32'h0);
    $display("test reset done");
    // Two words back to back, the second waits in the buffer
    wr(ssp_pkg::OFF_RX_STAT, 8'h80);
    wr(ssp_pkg::OFF_INT_CTRL, 8'hc1);
    for (int k = 0; k < 2; k++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      core_low_power <= 1'b0;
      wr(ssp_pkg::OFF_TX_STAT, 8'h30);
      wr(ssp_pkg::OFF_TX_BUF, a);
      wr(ssp_pkg::OFF_TX_BUF, b);
      rchk("empty flag clear", FLG, 32'h0);
      core_low_power <= 1'b1;
      @(posedge clk);
      chk("no wake while full", wake_req, 1'b0);
      chk("driving", data_pin_oe, 1'b1);
      sh(9'h000, 8);
      chk("first word", rx, {1'b0, a});
      chk("wake on empty", wake_req, 1'b1);
      chk("vector on empty", irq_vector, 1'b1);
      rchk("empty flag set", FLG, 32'h1);
      sh(9'h000, 8);
      chk("second word", rx, {1'b0, b});
      chk("released", data_pin_oe, 1'b0);
    end
    core_low_power <= 1'b0;
    wr(ssp_pkg::OFF_TX_STAT, 8'h71);
    wr(ssp_pkg::OFF_TX_BUF, a);
    sh(9'h000, 9);
    chk("nine bit word", rx, {1'b1, a});
    wr(ssp_pkg::OFF_TX_STAT, 8'h10);
    wr(ssp_pkg::OFF_TX_BUF, 8'h5a);
    chk("refused write", data_pin_oe, 1'b0);
    rchk("still empty", FLG, 32'h1);
    $display("test transmit done");
    // Single enable alone is ignored; continuous enable receives asleep
    w = 9'($urandom);
    wr(ssp_pkg::OFF_RX_STAT, 8'ha0);
    sh(w, 8);
    rchk("single ignored", FLG, 32'h1);
    wr(ssp_pkg::OFF_RX_STAT, 8'hd0);
    wr(ssp_pkg::OFF_INT_CTRL, 8'h42);
    core_low_power <= 1'b1;
    sh(w, 9);
    chk("wake on receive", wake_req, 1'b1);
    chk("masked vector", irq_vector, 1'b0);
    wr(ssp_pkg::OFF_INT_CTRL, 8'hc2);
    chk("vector", irq_vector, 1'b1);
    core_low_power <= 1'b0;
    rchk("full flag", FLG, 32'h3);
    rchk("ninth bit", ssp_pkg::OFF_RX_STAT, {24'h0, 7'h68, w[8]});
    rchk("rx data", ssp_pkg::OFF_RX_BUF, {24'h0, w[7:0]});
    rchk("full cleared", FLG, 32'h1);
    $display("test receive done");
    // Overrun from two unread words, cleared by dropping continuous receive
    sh(w, 9);
    sh(w, 9);
    rchk("overrun", ssp_pkg::OFF_RX_STAT, {24'h0, 7'h69, w[8]});
    wr(ssp_pkg::OFF_RX_STAT, 8'h80);
    rchk("error cleared", ssp_pkg::OFF_RX_STAT, {24'h0, 7'h40, w[8]});
    $display("test errors done");
    // Eight-bit reception: status read first, then the byte
    rchk("kept word", ssp_pkg::OFF_RX_BUF, {24'h0, w[7:0]});
    wr(ssp_pkg::OFF_RX_STAT, 8'h90);
    sh({1'b0, b}, 8);
    rchk("eight bit status", ssp_pkg::OFF_RX_STAT, 32'h90);
    rchk("eight bit data", ssp_pkg::OFF_RX_BUF, {24'h0, b});
    rchk("eight bit flags", FLG, 32'h1);
    $display("test eight bit receive done");
    print_verdict();
  end
endmodule // tb

/* hdl/ssp_shifter.sv */
/*
  Serial shifter on the external shift clock, found by sampling the
  synchronised clock pin with the system clock.
  Assumes the master shift clock is slow against clk (160 ns period).
*/
`timescale 1ns/10ps
module ssp_shifter (
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  sck_in,
  input  wire logic  sdat_in,
  output logic       sdat_out,
  output logic       sdat_oe,
  ssp_link_if.shifter lk
);
  typedef struct packed {
    logic [1:0] ck_sync;
    logic [1:0] dt_sync;
    logic       ck_last;
    logic [8:0] transmit_shift_register;
    logic [3:0] tx_cnt;
    logic       tx_act;
    logic [8:0] receive_shift_register;
    logic [3:0] rx_cnt;
    logic       done;
    logic [8:0] rword;
    logic       dout;
  } ssp_sh_t;

  ssp_sh_t st_r, st_nxt;
  logic    ck_rise, ck_fall;
  logic [3:0] rx_len;

  assign ck_rise = st_r.ck_sync[1] & ~st_r.ck_last;
  assign ck_fall = ~st_r.ck_sync[1] & st_r.ck_last;
  assign rx_len  = lk.rx_nine ? ssp_pkg::BITS_9 : ssp_pkg::BITS_8;

  // Synchronise pins, shift out on fall, sample in on fall
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ck_sync = {st_r.ck_sync[0], sck_in};
    st_nxt.dt_sync = {st_r.dt_sync[0], sdat_in};
    st_nxt.ck_last = st_r.ck_sync[1];
    st_nxt.done    = 1'b0;
    if (!lk.slave_on) begin
      st_nxt.tx_act = 1'b0;
      st_nxt.rx_cnt = 4'h0;
    end else begin
      if (lk.tx_load) begin
        st_nxt.transmit_shift_register    = lk.tx_word;
        st_nxt.tx_cnt = lk.tx_nine ? ssp_pkg::BITS_9 : ssp_pkg::BITS_8;
        st_nxt.tx_act = 1'b1;
        st_nxt.dout   = lk.tx_word[0];   // LSB first
      end else if (st_r.tx_act && ck_fall) begin
        st_nxt.transmit_shift_register    = {1'b0, st_r.transmit_shift_register[8:1]};
        st_nxt.dout   = st_r.transmit_shift_register[1];
        st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
        if (st_r.tx_cnt == 4'h1) begin
          st_nxt.tx_act = 1'b0;
        end
      end
      // Receive samples the data pin on the falling shift edge
      if (!lk.rx_en) begin
        st_nxt.rx_cnt = 4'h0;
      end else if (ck_fall && !st_r.tx_act) begin
        st_nxt.receive_shift_register    = {st_r.dt_sync[1], st_r.receive_shift_register[8:1]};
        st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
        if (st_r.rx_cnt + 4'h1 == rx_len) begin
          st_nxt.rx_cnt = 4'h0;
          st_nxt.done   = 1'b1;
          st_nxt.rword  = lk.rx_nine ? {st_r.dt_sync[1], st_r.receive_shift_register[8:1]}
                                     : {1'b0, st_r.dt_sync[1], st_r.receive_shift_register[8:2]};
        end
      end
    end
  end

  // Edges unused beyond fall; rise drops out of sdat_oe, which follows tx_act alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lk.tx_busy = st_r.tx_act | lk.tx_load;
  assign lk.rx_done = st_r.done;
  assign lk.rx_word = st_r.rword;
  assign sdat_out   = st_r.dout;
  assign sdat_oe    = st_r.tx_act & ~ck_rise | st_r.tx_act;
endmodule // ssp_shifter

/* hdl/ssp_top.sv */
/*
  Synchronous slave serial port: Wishbone register file, single-word
  transmit buffer, receive buffer with flags, wake and interrupt outputs.
  Assumes an external master drives the shift clock pin; both input pins are
  asynchronous to clk and are synchronised in the shifter.
*/
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
// Overview of operation
// - Clock-source-select cleared selects slave mode with external shift clock.
// - External clock lets the port run through every low-power mode.
// - Transfers match master mode apart from sleep and single-receive handling.
// - First of two written words moves at once to the shifter.
// - Second word waits in buffer, empty flag stays clear meanwhile.
// - Shifter empty: waiting word loads, then empty flag sets.
// - Transmit interrupt enable lets empty flag wake core; vector needs global.
// - Nine-bit select and ninth bit set before data byte; nine bits shift.
// - With transmit enabled, writing the transmit buffer starts transmission.
// - Single-receive enable ignored; continuous enable alone governs reception.
// - Continuous receive enabled before sleep accepts words during sleep.
// - Finished word moves to receive buffer; enabled interrupt wakes core.
// - Receive-buffer-full flag sets on completion; interrupt if enabled.
// - Ninth bit and errors in receive status, data byte in buffer.
// - Clearing continuous receive clears errors; software uses it to recover.
// - Received data sampled on falling edge of the shift clock.
module ssp_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        shift_clock_pin,
  input  wire logic        data_pin_in,
  output logic             data_pin_out,
  output logic             data_pin_oe,
  input  wire logic        core_low_power,
  output logic             wake_req,
  output logic             irq_vector
);
  typedef struct packed {
    logic [7:0] tx_stat;
    logic [7:0] rx_stat;
    logic [7:0] baud;
    logic [7:0] tx_buf;
    logic       tx_buf_ninth;
    logic       tx_buf_full;
    logic [7:0] rx_buf;
    logic       rx_full;
    logic [7:0] int_ctrl;
    logic       tx_load;
    logic       ack;
    logic [31:0] dat;
  } ssp_core_t;

  ssp_core_t st_r, st_nxt;
  ssp_link_if lk ();

  logic wr_req, rd_req, slave_on, tx_empty_flag, rx_pend;

  // Byte lane 0 carries every 8-bit register
  assign wr_req   = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~st_r.ack;
  assign rd_req   = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;
  // Slave only when serial port on, sync set and source select clear
  assign slave_on = st_r.rx_stat[ssp_pkg::RX_SERIAL_PORT_ENABLE] & st_r.tx_stat[ssp_pkg::TX_SYNC]
                  & ~st_r.tx_stat[ssp_pkg::TX_CLOCK_SOURCE_SELECT];
  assign tx_empty_flag = ~st_r.tx_buf_full & ~st_r.tx_load;
  assign rx_pend  = st_r.rx_full;

  assign lk.slave_on = slave_on;
  assign lk.tx_load  = st_r.tx_load;
  assign lk.tx_word  = {st_r.tx_buf_ninth, st_r.tx_buf};
  assign lk.tx_nine  = st_r.tx_stat[ssp_pkg::TX_TX9];
  // Single-receive enable plays no part here
  assign lk.rx_en    = st_r.rx_stat[ssp_pkg::RX_CONTINUOUS_RECEIVE_ENABLE];
  assign lk.rx_nine  = st_r.rx_stat[ssp_pkg::RX_RX9];

  // Register file, buffering and flags
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ack     = rd_req | (wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack);
    st_nxt.tx_load = 1'b0;
    st_nxt.tx_stat[ssp_pkg::TX_TRMT] = ~lk.tx_busy;
    // Buffered word moves as soon as the shifter is free
    if (st_r.tx_buf_full && !lk.tx_busy && !st_r.tx_load && slave_on
        && st_r.tx_stat[ssp_pkg::TX_TRANSMIT_ENABLE]) begin
      st_nxt.tx_load     = 1'b1;
      st_nxt.tx_buf_full = 1'b0;
    end
    // Completed word lands in the receive buffer
    if (lk.rx_done) begin
      if (st_r.rx_full) begin
        st_nxt.rx_stat[ssp_pkg::RX_OVERRUN_ERROR_FLAG] = 1'b1;                   // Word lost
      end else begin
        st_nxt.rx_buf  = lk.rx_word[7:0];
        st_nxt.rx_full = 1'b1;
        st_nxt.rx_stat[ssp_pkg::RX_RECEIVE_NINTH_BIT] = lk.rx_word[8];
      end
    end
    // Reading the receive buffer frees it
    if (rd_req && wb_adr_i == ssp_pkg::OFF_RX_BUF && !lk.rx_done) begin
      st_nxt.rx_full = 1'b0;
    end
    if (wr_req) begin
      unique case (wb_adr_i)
        ssp_pkg::OFF_TX_STAT: begin
          st_nxt.tx_stat = {wb_dat_i[7:2], st_nxt.tx_stat[ssp_pkg::TX_TRMT],
                            wb_dat_i[0]};
        end
        ssp_pkg::OFF_RX_STAT: begin
          st_nxt.rx_stat[7:3] = wb_dat_i[7:3];
          // Dropping continuous receive clears pending errors
          if (!wb_dat_i[ssp_pkg::RX_CONTINUOUS_RECEIVE_ENABLE]) begin
            st_nxt.rx_stat[ssp_pkg::RX_OVERRUN_ERROR_FLAG] = lk.rx_done & st_r.rx_full; // Set wins
            st_nxt.rx_stat[ssp_pkg::RX_FRAMING_ERROR_FLAG] = 1'b0;
          end
        end
        ssp_pkg::OFF_BAUD:     st_nxt.baud     = wb_dat_i[7:0];
        ssp_pkg::OFF_INT_CTRL: st_nxt.int_ctrl = wb_dat_i[7:0];
        ssp_pkg::OFF_TX_BUF: begin
          // Ninth bit latched with the byte, so it must be set first
          if (st_r.tx_stat[ssp_pkg::TX_TRANSMIT_ENABLE] && !st_r.tx_buf_full) begin
            st_nxt.tx_buf       = wb_dat_i[7:0];
            st_nxt.tx_buf_ninth = st_r.tx_stat[ssp_pkg::TX_TRANSMIT_NINTH_BIT];
            st_nxt.tx_buf_full  = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Read mux, unmapped offsets read zero
    st_nxt.dat = 32'h0000_0000;
    if (rd_req) begin
      unique case (wb_adr_i)
        ssp_pkg::OFF_TX_STAT:  st_nxt.dat[7:0] = st_r.tx_stat;
        ssp_pkg::OFF_RX_STAT:  st_nxt.dat[7:0] = st_r.rx_stat;
        ssp_pkg::OFF_BAUD:     st_nxt.dat[7:0] = st_r.baud;
        ssp_pkg::OFF_RX_BUF:   st_nxt.dat[7:0] = st_r.rx_buf;
        ssp_pkg::OFF_INT_CTRL: st_nxt.dat[7:0] = st_r.int_ctrl;
        ssp_pkg::OFF_INT_FLAG: st_nxt.dat[1:0] = {rx_pend, tx_empty_flag};
        default:               st_nxt.dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r          <= '0;
      st_r.tx_stat  <= ssp_pkg::TX_STAT_RST;
      st_r.rx_stat  <= ssp_pkg::RX_STAT_RST;
      st_r.baud     <= ssp_pkg::BAUD_RST;
      st_r.int_ctrl <= ssp_pkg::INT_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Shifter keeps running whatever the core power state
  ssp_shifter u_shifter (
    .clk      (clk),
    .rst      (rst),
    .sck_in   (shift_clock_pin),
    .sdat_in  (data_pin_in),
    .sdat_out (data_pin_out),
    .sdat_oe  (data_pin_oe),
    .lk       (lk)
  );

  // Wake needs only the local enable; vectoring also needs global/peripheral
  logic tx_int, rx_int;
  assign tx_int     = tx_empty_flag & st_r.int_ctrl[ssp_pkg::IC_TRANSMIT_INTERRUPT_ENABLE];
  assign rx_int     = rx_pend & st_r.int_ctrl[ssp_pkg::IC_RECEIVE_INTERRUPT_ENABLE];
  assign wake_req   = core_low_power & (tx_int | rx_int);
  assign irq_vector = (tx_int | rx_int) & st_r.int_ctrl[ssp_pkg::IC_GIE]
                    & st_r.int_ctrl[ssp_pkg::IC_PERIPHERAL_INTERRUPT_ENABLE];
  assign wb_ack_o   = st_r.ack;
  assign wb_dat_o   = st_r.dat;
endmodule // ssp_top

/* include/ssp_link_if.sv */
/*
  Bundle between the register core and the serial shifter.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface ssp_link_if;
  logic       tx_load;    // Pulse: take a word into the shifter
  logic [8:0] tx_word;
  logic       tx_nine;
  logic       tx_busy;
  logic       rx_en;
  logic       rx_nine;
  logic       rx_done;    // Pulse: a word has been received
  logic [8:0] rx_word;
  logic       slave_on;

  modport core (output tx_load, output tx_word, output tx_nine, output rx_en,
                output rx_nine, output slave_on, input tx_busy, input rx_done,
                input rx_word);
  modport shifter (input tx_load, input tx_word, input tx_nine, input rx_en,
                   input rx_nine, input slave_on, output tx_busy, output rx_done,
                   output rx_word);
endinterface // ssp_link_if

/* include/ssp_pkg.sv */
/*
  Shared constants for the synchronous slave serial port: register
  offsets, bit positions, reset values and shifter sizes.
  Assumes a classic Wishbone slave with 32-bit data, byte addresses.
*/
package ssp_pkg;
  // Register byte offsets
  localparam logic [4:0] OFF_TX_STAT  = 5'h00;
  localparam logic [4:0] OFF_RX_STAT  = 5'h04;
  localparam logic [4:0] OFF_BAUD     = 5'h08;
  localparam logic [4:0] OFF_TX_BUF   = 5'h0c;
  localparam logic [4:0] OFF_RX_BUF   = 5'h10;
  localparam logic [4:0] OFF_INT_CTRL = 5'h14;
  localparam logic [4:0] OFF_INT_FLAG = 5'h18;
  // Transmit status/control bit positions
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_TX9  = 6;
  localparam int TX_TRANSMIT_ENABLE = 5;
  localparam int TX_SYNC = 4;
  localparam int TX_TRMT = 1;
  localparam int TX_TRANSMIT_NINTH_BIT = 0;
  // Receive status/control bit positions
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_RX9  = 6;
  localparam int RX_SINGLE_RECEIVE_ENABLE = 5;
  localparam int RX_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RX_FRAMING_ERROR_FLAG = 2;
  localparam int RX_OVERRUN_ERROR_FLAG = 1;
  localparam int RX_RECEIVE_NINTH_BIT = 0;
  // Interrupt control and flag positions
  localparam int IC_GIE  = 7;
  localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int IC_RECEIVE_INTERRUPT_ENABLE = 1;
  localparam int IC_TRANSMIT_INTERRUPT_ENABLE = 0;
  localparam int IF_RECEIVE_BUFFER_FULL_FLAG = 1;
  localparam int IF_TRANSMIT_BUFFER_EMPTY_FLAG = 0;
  // Reset values
  localparam logic [7:0] TX_STAT_RST  = 8'h02;
  localparam logic [7:0] RX_STAT_RST  = 8'h00;
  localparam logic [7:0] BAUD_RST     = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  // Shifter word lengths
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
endpackage
